/* hw/adapter_defs.svh */
// constants of the altitude serial to parallel adapter
`ifndef ADAPTER_DEFS_SVH
`define ADAPTER_DEFS_SVH

`define CLK_HZ 100000000
`define CLK_PERIOD_NS 10
`define BAUD_ENC 9600
`define BAUD_LOW 1200
`define BAUD_MID 2400
`define BAUD_HIGH 9600
`define UPDATE_PERIOD_S 1
`define INIT_MSGS 2'h3

`define REG_CONFIG 4'h0
`define REG_STATUS 4'h4
`define REG_ALTITUDE 4'h8
`define REG_CODE 4'hc
`define CONFIG_RESET 12'h000

`define PROTO_STRAP 3'h0
`define PROTO_HASH 3'h1
`define PROTO_ALT_HIGH 3'h2
`define PROTO_ALT_MID 3'h3
`define PROTO_MGL 3'h4
`define PROTO_ALT_AUX 3'h5
`define RES_FINE 4'h2
`define LEN_LONG 5'h11
`define LEN_SHORT 5'h0a

`define CH_CR 8'h0d
`define CH_LF 8'h0a
`define CH_SPACE 8'h20
`define CH_MINUS 8'h2d
`define CH_PLUS 8'h2b
`define CH_ZERO 8'h30
`define CH_NINE 8'h39
`define CH_A 8'h41
`define CH_L 8'h4c
`define CH_T 8'h54
`define CH_P 8'h50
`define ALT_PREFIX "ALT "
`define HASH_PREFIX "#AL"
`define MGL_PREFIX "$MGL"
`define HASH_TRAILER "T+25D8"
`define MGL_TRAILER "T+25D6"
`define DIS_HIGH "99900"
`define DIS_MID "-2500"
`define MSG_PAD 56'h0

`define GILLHAM_BASE 11'h00c
`define GROUP_SIZE 11'h005
`define GROUP_TOP 11'h004

`endif

/* hw/adapter_pkg.sv */
// types shared by the adapter modules
package adapter_pkg;
    typedef enum logic [1:0] {
        IDLE = 2'b00,
        START = 2'b01,
        DATA = 2'b11,
        STOP = 2'b10
    } serial_state_type;
endpackage : adapter_pkg

/* hw/serial_rx.sv */
// asynchronous 8n1 receiver with framing check
`timescale 1ns/1ps
module serial_rx #(
    parameter int BIT_CYCLES = 10417
) (
    input wire logic clk_sys, // system clock
    input wire logic srst, // synchronous reset
    input wire logic serial_in, // line, idle high
    output logic [7:0] byte_data, // received byte
    output logic byte_valid, // pulse, byte good
    output logic frame_err // pulse, stop bit low
);
    localparam int CW = $clog2(BIT_CYCLES + 1) + 1;
    localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);
    localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2 - 1);

    adapter_pkg::serial_state_type state;
    logic [CW-1:0] cnt;
    logic [2:0] bitn;
    logic [7:0] shift;
    wire expired = (cnt == '0);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= adapter_pkg::IDLE;
            cnt <= '0;
            bitn <= 3'h0;
            shift <= 8'h00;
            byte_data <= 8'h00;
            byte_valid <= 1'b0;
            frame_err <= 1'b0;
        end else begin
            byte_valid <= 1'b0;
            frame_err <= 1'b0;
            cnt <= expired ? FULL : cnt - 1'b1;
            case (state)
                adapter_pkg::IDLE: begin
                    cnt <= HALF;
                    if (!serial_in) begin
                        state <= adapter_pkg::START;
                    end
                end
                adapter_pkg::START: begin
                    // mid-bit recheck rejects glitches shorter than half a bit
                    if (expired) begin
                        state <= serial_in ? adapter_pkg::IDLE : adapter_pkg::DATA;
                        bitn <= 3'h0;
                    end
                end
                adapter_pkg::DATA: begin
                    if (expired) begin
                        shift <= {serial_in, shift[7:1]};
                        bitn <= bitn + 1'b1;
                        if (bitn == 3'h7) begin
                            state <= adapter_pkg::STOP;
                        end
                    end
                end
                adapter_pkg::STOP: begin
                    if (expired) begin
                        state <= adapter_pkg::IDLE;
                        byte_data <= shift;
                        byte_valid <= serial_in;
                        frame_err <= !serial_in;
                    end
                end
                default: state <= adapter_pkg::IDLE;
            endcase
        end
    end
endmodule : serial_rx

/* hw/altitude_adapter.sv */
// altitude adapter: serial altitude in, gray parallel code and two serial reports out
//
// How it works
// RULE_01 - encoder input is 9600 baud 8n1 ascii
// RULE_02 - parallel code low until three valid messages
// RULE_03 - parallel code follows latest altitude, gray coded
// RULE_04 - strobe high disables code, grounded enables
// RULE_05 - strobe never touches serial transmissions
// RULE_06 - serial reports start only after initialisation
// RULE_07 - start/stop framing, baud per chosen protocol
// RULE_08 - grounded straps override software configuration
// RULE_09 - resolution strap forces 10-foot output
// RULE_10 - no protocol strap: '#AL' message, 1200 baud
// RULE_11 - strap b: 'ALT ' 9600, 99900 when disabled
// RULE_12 - strap a: 'ALT ' 2400, -2500 when disabled
// RULE_13 - both straps: '$MGL' message, 1200 baud
// RULE_14 - both outputs share protocol unless assigned
// RULE_15 - config input only configures, never altitude
// RULE_16 - three config digits: resolution, protocol a, b
// RULE_17 - only well formed messages count as valid
// RULE_18 - reports repeat each interval with latest altitude
`timescale 1ns/1ps
`include "adapter_defs.svh"
module altitude_serial_to_parallel_adapter #(
    parameter int CLK_HZ = `CLK_HZ,
    parameter int DIV_HIGH = (CLK_HZ + `BAUD_HIGH / 2) / `BAUD_HIGH,
    parameter int DIV_MID = (CLK_HZ + `BAUD_MID / 2) / `BAUD_MID,
    parameter int DIV_LOW = (CLK_HZ + `BAUD_LOW / 2) / `BAUD_LOW,
    parameter int UPDATE_CYCLES = CLK_HZ * `UPDATE_PERIOD_S
) (
    input wire logic clk_sys, // system clock, 100 mhz
    input wire logic srst, // synchronous reset, active high
    input wire logic [3:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // low marks the answer
    input wire logic encoder_serial_in, // altitude from encoder
    input wire logic config_serial_in, // configuration console
    input wire logic strap_res_n, // low selects 10-foot output
    input wire logic strap_a_n, // protocol strap a, low grounded
    input wire logic strap_b_n, // protocol strap b, low grounded
    input wire logic strobe_in, // high disables parallel code
    output logic [10:0] alt_code, // d2 d4 a1 a2 a4 b1 b2 b4 c1 c2 c4
    output logic nav_serial_out_a, // serial report a
    output logic nav_serial_out_b // serial report b
);
    localparam int CW = $clog2(DIV_LOW + 1);
    localparam int UW = $clog2(UPDATE_CYCLES + 1);

    logic [7:0] enc_byte;
    logic enc_valid;
    logic enc_err;
    logic [7:0] cfg_byte;
    logic cfg_valid;
    logic [3:0] pos;
    logic [39:0] field;
    logic msg_valid;
    logic [1:0] valid_count;
    logic initialised;
    logic [19:0] alt_bcd;
    logic alt_neg;
    logic [2:0] cfg_pos;
    logic [11:0] cfg_shift;
    logic [11:0] config_word;
    logic [UW-1:0] upd_cnt;
    logic update_tick;
    logic msg_seen;
    logic source_disabled;
    logic [19:0] snap_bcd;
    logic snap_neg;
    logic snap_dis;
    logic snap_fine;

    serial_rx #(.BIT_CYCLES(DIV_HIGH)) u_enc_rx ( // RULE_01
        .clk_sys(clk_sys),
        .srst(srst),
        .serial_in(encoder_serial_in),
        .byte_data(enc_byte),
        .byte_valid(enc_valid),
        .frame_err(enc_err)
    );

    serial_rx #(.BIT_CYCLES(DIV_HIGH)) u_cfg_rx (
        .clk_sys(clk_sys),
        .srst(srst),
        .serial_in(config_serial_in),
        .byte_data(cfg_byte),
        .byte_valid(cfg_valid),
        .frame_err()
    );

    // encoder message parser
    wire is_digit = (enc_byte >= `CH_ZERO) && (enc_byte <= `CH_NINE);
    wire in_field = (pos >= 4'h4) && (pos <= 4'h8);
    wire char_ok = (pos == 4'h0) ? enc_byte == `CH_A :
                   (pos == 4'h1) ? enc_byte == `CH_L :
                   (pos == 4'h2) ? enc_byte == `CH_T :
                   (pos == 4'h3) ? enc_byte == `CH_SPACE :
                   (pos == 4'h4) ? (is_digit || enc_byte == `CH_MINUS) :
                   in_field ? is_digit : enc_byte == `CH_CR;
    wire msg_done = enc_valid && char_ok && (pos == 4'h9);
    wire msg_bad = enc_err || (enc_valid && !char_ok);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pos <= 4'h0;
            field <= 40'h0;
            msg_valid <= 1'b0;
        end else begin
            msg_valid <= msg_done; // RULE_17
            if (msg_bad) begin
                pos <= (enc_valid && enc_byte == `CH_A) ? 4'h1 : 4'h0; // RULE_17
            end else if (enc_valid) begin
                pos <= msg_done ? 4'h0 : pos + 1'b1;
                if (in_field) begin
                    field <= {field[31:0], enc_byte};
                end
            end
        end
    end

    // altitude only ever comes from the encoder parser
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            valid_count <= 2'h0;
            initialised <= 1'b0;
            alt_bcd <= 20'h0;
            alt_neg <= 1'b0;
        end else begin
            if (msg_valid) begin
                alt_neg <= field[39:32] == `CH_MINUS; // RULE_15
                alt_bcd <= {field[39:32] == `CH_MINUS ? 4'h0 : field[35:32],
                            field[27:24], field[19:16], field[11:8], field[3:0]};
            end
            if (msg_valid && !initialised) begin
                valid_count <= valid_count + 1'b1; // RULE_02
                initialised <= (valid_count + 1'b1) == `INIT_MSGS; // RULE_06
            end else if (msg_bad && !initialised) begin
                valid_count <= 2'h0; // RULE_17
            end
        end
    end

    // gray code: 500-ft groups reflected binary, 100-ft steps in c bits
    wire [10:0] hund = {7'h0, alt_bcd[19:16]} * 11'h064 + {7'h0, alt_bcd[15:12]} * 11'h00a
                     + {7'h0, alt_bcd[11:8]} + {10'h0, alt_bcd[7:4] >= 4'h5};
    wire [10:0] steps = alt_neg ? ((hund > `GILLHAM_BASE) ? 11'h0 : `GILLHAM_BASE - hund)
                                : `GILLHAM_BASE + hund;
    wire [10:0] group = steps / `GROUP_SIZE;
    wire [10:0] rem_raw = steps % `GROUP_SIZE;
    wire [10:0] rem = group[0] ? `GROUP_TOP - rem_raw : rem_raw;
    wire [7:0] gray_group = group[7:0] ^ {1'b0, group[7:1]};
    wire [2:0] c_bits = (rem == 11'h0) ? 3'h1 : (rem == 11'h1) ? 3'h3 :
                        (rem == 11'h2) ? 3'h2 : (rem == 11'h3) ? 3'h6 : 3'h4;
    wire [10:0] gillham_code = {gray_group, c_bits[0], c_bits[1], c_bits[2]};

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            alt_code <= 11'h0;
        end else begin
            alt_code <= (initialised && !strobe_in) ? gillham_code : 11'h0; // RULE_02 RULE_03 RULE_04
        end
    end

    // console command: 'P' digit digit digit CR
    wire cfg_digit = (cfg_byte >= `CH_ZERO) && (cfg_byte <= `CH_NINE);
    wire cfg_ok = (cfg_pos == 3'h0) ? cfg_byte == `CH_P :
                  (cfg_pos == 3'h4) ? cfg_byte == `CH_CR : cfg_digit;
    wire cfg_done = cfg_valid && cfg_ok && (cfg_pos == 3'h4);
    wire bus_req = avs_read || avs_write;
    wire bus_take = bus_req && !avs_waitrequest;
    wire bus_cfg_wr = bus_take && avs_write && (avs_address == `REG_CONFIG);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_pos <= 3'h0;
            cfg_shift <= 12'h0;
            config_word <= `CONFIG_RESET;
        end else begin
            if (cfg_valid) begin
                cfg_pos <= (cfg_ok && !cfg_done) ? cfg_pos + 1'b1 : 3'h0;
                cfg_shift <= {cfg_shift[7:0], cfg_byte[3:0]};
            end
            // a bus write in the same cycle as a console command wins
            if (bus_cfg_wr) begin
                config_word <= avs_writedata[11:0]; // RULE_16
            end else if (cfg_done) begin
                config_word <= cfg_shift; // RULE_15 RULE_16
            end
        end
    end

    // digit order: resolution, protocol a, protocol b
    wire [3:0] cfg_res = config_word[11:8];
    wire [3:0] cfg_pa = config_word[7:4];
    wire [3:0] cfg_pb = config_word[3:0];
    wire strap_any = !strap_a_n || !strap_b_n;
    wire [2:0] strap_proto = (!strap_a_n && !strap_b_n) ? `PROTO_MGL : // RULE_13
                             !strap_b_n ? `PROTO_ALT_HIGH : // RULE_11
                             !strap_a_n ? `PROTO_ALT_MID : `PROTO_HASH; // RULE_12 RULE_10
    wire pa_ok = (cfg_pa != 4'h0) && (cfg_pa <= {1'b0, `PROTO_ALT_AUX});
    wire pb_ok = (cfg_pb != 4'h0) && (cfg_pb <= {1'b0, `PROTO_ALT_AUX});
    wire [2:0] proto_a_eff = strap_any ? strap_proto : pa_ok ? cfg_pa[2:0] : `PROTO_HASH; // RULE_08
    wire [2:0] proto_b_eff = strap_any ? strap_proto : pb_ok ? cfg_pb[2:0] : `PROTO_HASH; // RULE_14
    wire fine_res = !strap_res_n || (cfg_res == `RES_FINE); // RULE_08 RULE_09

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            upd_cnt <= '0;
            update_tick <= 1'b0;
        end else begin
            update_tick <= upd_cnt == UW'(UPDATE_CYCLES - 1); // RULE_18
            upd_cnt <= (upd_cnt == UW'(UPDATE_CYCLES - 1)) ? '0 : upd_cnt + 1'b1;
        end
    end

    // a silent encoder for a whole interval marks the source disabled
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            msg_seen <= 1'b0;
            source_disabled <= 1'b0;
            snap_bcd <= 20'h0;
            snap_neg <= 1'b0;
            snap_dis <= 1'b0;
            snap_fine <= 1'b0;
        end else if (update_tick) begin
            msg_seen <= msg_valid;
            source_disabled <= !msg_seen && !msg_valid;
            snap_bcd <= alt_bcd; // RULE_18
            snap_neg <= alt_neg;
            snap_dis <= !msg_seen && !msg_valid;
            snap_fine <= fine_res;
        end else if (msg_valid) begin
            msg_seen <= 1'b1;
        end
    end

    // coarse output truncates tens and units to zero
    wire [3:0] out_tens = snap_fine ? snap_bcd[7:4] : 4'h0; // RULE_09
    wire [3:0] out_units = snap_fine ? snap_bcd[3:0] : 4'h0;
    wire [39:0] snap_ascii = {`CH_ZERO | {4'h0, snap_bcd[19:16]}, `CH_ZERO | {4'h0, snap_bcd[15:12]},
                              `CH_ZERO | {4'h0, snap_bcd[11:8]}, `CH_ZERO | {4'h0, out_tens},
                              `CH_ZERO | {4'h0, out_units}};

    function automatic logic [135:0] build_msg(input logic [2:0] p, input logic [39:0] digits,
                                               input logic neg, input logic dis);
        logic [39:0] fld;
        logic [7:0] sgn;
        fld = neg ? {`CH_MINUS, digits[31:0]} : digits;
        sgn = neg ? `CH_MINUS : `CH_PLUS;
        case (p)
            `PROTO_HASH: build_msg = {`HASH_PREFIX, sgn, digits, `HASH_TRAILER, `CH_CR, `CH_LF}; // RULE_10
            `PROTO_MGL: build_msg = {`MGL_PREFIX, sgn, digits, `MGL_TRAILER, `CH_CR}; // RULE_13
            `PROTO_ALT_MID: build_msg = {`ALT_PREFIX, dis ? `DIS_MID : fld, `CH_CR, `MSG_PAD}; // RULE_12
            default: build_msg = {`ALT_PREFIX, dis ? `DIS_HIGH : fld, `CH_CR, `MSG_PAD}; // RULE_11
        endcase
    endfunction : build_msg

    function automatic logic [CW-1:0] bit_div(input logic [2:0] p);
        case (p)
            `PROTO_HASH, `PROTO_MGL: bit_div = CW'(DIV_LOW - 1);
            `PROTO_ALT_MID: bit_div = CW'(DIV_MID - 1);
            default: bit_div = CW'(DIV_HIGH - 1);
        endcase
    endfunction : bit_div

    for (genvar ch = 0; ch < 2; ch++) begin : g_tx
        adapter_pkg::serial_state_type state;
        logic [CW-1:0] cnt;
        logic [2:0] bitn;
        logic [4:0] idx;
        logic [7:0] shift;
        logic [2:0] proto;
        logic line;
        wire [2:0] sel_proto = (ch == 0) ? proto_a_eff : proto_b_eff;
        wire [135:0] msg = build_msg(proto, snap_ascii, snap_neg, snap_dis);
        wire [7:0] cur = msg[8'h80 - {idx, 3'h0} +: 8];
        wire [4:0] last = (proto == `PROTO_HASH || proto == `PROTO_MGL) ? `LEN_LONG - 1'b1
                                                                        : `LEN_SHORT - 1'b1;
        wire expired = (cnt == '0);

        always_ff @(posedge clk_sys) begin
            if (srst) begin
                state <= adapter_pkg::IDLE;
                cnt <= '0;
                bitn <= 3'h0;
                idx <= 5'h0;
                shift <= 8'h00;
                proto <= `PROTO_HASH;
                line <= 1'b1;
            end else begin
                cnt <= expired ? bit_div(proto) : cnt - 1'b1;
                case (state)
                    adapter_pkg::IDLE: begin
                        line <= 1'b1;
                        // strobe_in plays no part in starting or pacing a report
                        if (update_tick && initialised) begin // RULE_05 RULE_06 RULE_18
                            state <= adapter_pkg::START;
                            proto <= sel_proto; // RULE_14
                            cnt <= bit_div(sel_proto); // RULE_07
                            idx <= 5'h0;
                            line <= 1'b0;
                        end
                    end
                    adapter_pkg::START: begin
                        if (expired) begin
                            state <= adapter_pkg::DATA;
                            shift <= {1'b0, cur[7:1]};
                            line <= cur[0]; // RULE_07
                            bitn <= 3'h0;
                        end
                    end
                    adapter_pkg::DATA: begin
                        if (expired) begin
                            bitn <= bitn + 1'b1;
                            shift <= {1'b0, shift[7:1]};
                            line <= (bitn == 3'h7) ? 1'b1 : shift[0];
                            state <= (bitn == 3'h7) ? adapter_pkg::STOP : adapter_pkg::DATA;
                        end
                    end
                    adapter_pkg::STOP: begin
                        if (expired) begin
                            state <= (idx == last) ? adapter_pkg::IDLE : adapter_pkg::START;
                            line <= idx == last;
                            idx <= idx + 1'b1;
                        end
                    end
                    default: state <= adapter_pkg::IDLE;
                endcase
            end
        end
    end

    assign nav_serial_out_a = g_tx[0].line;
    assign nav_serial_out_b = g_tx[1].line;

    // register slave: one wait cycle, answer on the second edge
    wire [31:0] status_word = {21'h0, fine_res, proto_b_eff, proto_a_eff, source_disabled,
                               valid_count, initialised};
    wire [31:0] read_mux = (avs_address == `REG_CONFIG) ? {20'h0, config_word} :
                           (avs_address == `REG_STATUS) ? status_word :
                           (avs_address == `REG_ALTITUDE) ? {11'h0, alt_neg, alt_bcd} :
                           (avs_address == `REG_CODE) ? {21'h0, alt_code} : 32'h0;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            avs_waitrequest <= !(bus_req && avs_waitrequest);
            if (bus_req && avs_waitrequest) begin
                avs_readdata <= avs_read ? read_mux : 32'h0;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_code_low_uninit: assert property (!initialised |=> alt_code == 11'h0) // RULE_02
        else $error("parallel code active before initialisation");
    a_code_strobe_off: assert property (initialised && strobe_in |=> alt_code == 11'h0) // RULE_04
        else $error("parallel code driven while strobe high");
    a_code_follows: assert property (initialised && !strobe_in |=> alt_code == $past(gillham_code)) // RULE_03
        else $error("parallel code does not follow altitude");
    a_init_after_three: assert property ($rose(initialised) |-> $past(msg_valid) && $past(valid_count) == 2'h2) // RULE_02
        else $error("initialised without three valid messages");
    a_tx_quiet_uninit: assert property (!initialised |-> nav_serial_out_a && nav_serial_out_b) // RULE_06
        else $error("serial report before initialisation");
    a_tx_starts_tick: assert property ($fell(nav_serial_out_a) && $past(g_tx[0].state) == adapter_pkg::IDLE |-> $past(update_tick)) // RULE_18
        else $error("report started off the interval tick");
    a_strap_b_proto: assert property (!strap_b_n && strap_a_n |-> proto_a_eff == `PROTO_ALT_HIGH && proto_b_eff == `PROTO_ALT_HIGH) // RULE_08
        else $error("strap b does not override software");
    a_both_strap_proto: assert property (!strap_a_n && !strap_b_n |-> proto_a_eff == `PROTO_MGL) // RULE_13
        else $error("both straps do not select dollar protocol");
    a_res_strap_fine: assert property (!strap_res_n |-> fine_res) // RULE_09
        else $error("resolution strap ignored");
    a_shared_proto: assert property (cfg_pa == 4'h0 && cfg_pb == 4'h0 |-> proto_a_eff == proto_b_eff) // RULE_14
        else $error("outputs differ without separate assignment");
    a_bus_answer: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle wide");

    c_initialised: cover property ($rose(initialised));
    c_strobe_gate: cover property (initialised && strobe_in ##1 !strobe_in);
    c_report_start: cover property (update_tick && initialised ##1 !nav_serial_out_a);
    c_console_cfg: cover property (cfg_done);
endmodule : altitude_serial_to_parallel_adapter

/* bench/encoder_model.sv */
// altitude encoder model: 8n1 ascii sender, line idle high
`timescale 1ns/1ps
module encoder_model #(
    parameter int BIT_CYCLES = 10
) (
    input wire logic clk_sys, // system clock
    output logic line // serial line to the adapter
);
    initial line = 1'b1;
    // start bit, eight data bits lsb first, one stop bit, no gap
    task automatic send(input string s);
        logic [9:0] f;
        for (int i = 0; i < s.len(); i++) begin
            f = {1'b1, s[i], 1'b0};
            for (int b = 0; b < 10; b++) begin
                line <= f[b];
                repeat (BIT_CYCLES) @(posedge clk_sys);
            end
        end
    endtask : send
endmodule : encoder_model

/* bench/tb_altitude_serial_to_parallel_adapter.sv */
// self-checking bench of the altitude adapter
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_altitude_serial_to_parallel_adapter;
    logic clk_sys = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, encoder_serial_in, nav_serial_out_a, nav_serial_out_b;
    logic config_serial_in;
    logic strap_res_n = 1'b1, strap_a_n = 1'b1, strap_b_n = 1'b0, strobe_in = 1'b0;
    logic [10:0] alt_code;
    int error_cnt = 0, n_tests = 0;
    always #5 clk_sys = ~clk_sys;
    // a short clock divides the baud counts: 9600 -> 10, 2400 -> 40 cycles a bit
    altitude_serial_to_parallel_adapter #(.CLK_HZ(96000), .UPDATE_CYCLES(14000))
    altitude_serial_to_parallel_adapter_inst (.clk_sys(clk_sys), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .encoder_serial_in(encoder_serial_in),
        .config_serial_in(config_serial_in), .strap_res_n(strap_res_n), .strap_a_n(strap_a_n),
        .strap_b_n(strap_b_n), .strobe_in(strobe_in), .alt_code(alt_code),
        .nav_serial_out_a(nav_serial_out_a), .nav_serial_out_b(nav_serial_out_b));
    encoder_model #(.BIT_CYCLES(10)) encoder_model_inst (.clk_sys(clk_sys),
        .line(encoder_serial_in));
    // the console speaks the same 8n1 framing as the encoder
    encoder_model #(.BIT_CYCLES(10)) console_inst (.clk_sys(clk_sys), .line(config_serial_in));
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    // sample one report mid-bit; both outputs must carry the same frame
    task automatic grab(input string s, input int div);
        logic [7:0] c;
        for (int i = 0; i < s.len(); i++) begin
            while (nav_serial_out_a) @(posedge clk_sys);
            repeat (div / 2) @(posedge clk_sys);
            for (int b = 0; b < 8; b++) begin
                repeat (div) @(posedge clk_sys);
                c[b] = nav_serial_out_a;
                `CHK(nav_serial_out_b, nav_serial_out_a)
            end
            `CHK(c, s[i])
            repeat (div) @(posedge clk_sys);
        end
    endtask : grab
    task automatic check_bus();
        bus(1'b1, 4'h0, 32'h033);
        bus(1'b0, 4'h0, 32'h0);
        `CHK(q[11:0], 12'h033)
        console_inst.send("P012\r");
        bus(1'b0, 4'h0, 32'h0);
        `CHK(q[11:0], 12'h012)
        bus(1'b0, 4'h2, 32'h0);
        `CHK(q, 32'h0)
    endtask : check_bus
    task automatic check_init();
        encoder_model_inst.send("ALT 01050\r");
        encoder_model_inst.send("ALT 01x00\r");
        encoder_model_inst.send("ALT 01050\r");
        encoder_model_inst.send("ALT 01050\r");
        repeat (20) @(posedge clk_sys);
        `CHK(alt_code, 11'h000)
        `CHK(nav_serial_out_a, 1'b1)
        encoder_model_inst.send("ALT 01050\r");
        repeat (20) @(posedge clk_sys);
        bus(1'b0, 4'h4, 32'h0);
        `CHK(q[0], 1'b1)
        `CHK(alt_code, 11'h033)
        strobe_in <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHK(alt_code, 11'h000)
    endtask : check_init
    // strap b beats the software digits; then strap a with a silent source
    task automatic check_reports();
        strap_res_n <= 1'b0;
        grab("ALT 01050\r", 10);
        strap_a_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        bus(1'b0, 4'h4, 32'h0);
        `CHK(q[6:4], 3'h4)
        strap_b_n <= 1'b1;
        grab("ALT -2500\r", 40);
    endtask : check_reports
    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        `CHK(alt_code, 11'h000)
        check_bus();
        check_init();
        check_reports();
        conclude();
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        error_cnt++;
        conclude();
    end
endmodule : tb_altitude_serial_to_parallel_adapter
